// [inc/ftc_pkg.sv]
// Constants, lookup tables and carrier types for the fault threshold settings word.
// Assumes one clock domain; all measurement inputs come from logic on that clock.
package ftc_pkg;

    // ------------------------------------------------------------------
    // Register placement and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0]  FTC_REG_OFFSET     = 8'h94;
    localparam logic [31:0] FTC_REG_RESET      = 32'h0000_0000;
    localparam int          FTC_PARITY_BIT     = 31;
    localparam int          FTC_ABN_EN_BIT     = 30;
    localparam int          FTC_SYNC_EN_BIT    = 29;
    localparam int          FTC_ABSENT_EN_BIT  = 28;
    localparam int          FTC_ABN_LSB        = 24;
    localparam int          FTC_SYNC_LSB       = 21;
    localparam int          FTC_ABSENT_LSB     = 18;
    localparam int          FTC_OV_MODE_BIT    = 17;
    localparam int          FTC_VMAX_LSB       = 14;
    localparam int          FTC_UV_MODE_BIT    = 13;
    localparam int          FTC_VMIN_LSB       = 10;
    localparam int          FTC_RETRY_LSB      = 7;
    localparam int          FTC_MINSPD_LSB     = 4;
    localparam int          FTC_RATIO_LSB      = 2;
    localparam int          FTC_DUTY_LSB       = 0;

    // ------------------------------------------------------------------
    // Lookup constants (speed in 0.5 Hz, sense in 0.5 mV, supply in 0.1 V,
    // duty in 0.1 percent)
    // ------------------------------------------------------------------
    localparam logic [12:0] FTC_ABN_STEP       = 13'h1f4;
    localparam logic [3:0]  FTC_SYNC_BASE      = 4'h2;
    localparam logic [9:0]  FTC_ABSENT_LUT [8] = '{10'h00a, 10'h00f, 10'h014, 10'h019,
                                                   10'h028, 10'h032, 10'h03c, 10'h050};
    localparam logic [9:0]  FTC_VMAX_LUT   [8] = '{10'h000, 10'h0c8, 10'h0fa, 10'h12c,
                                                   10'h15e, 10'h190, 10'h1f4, 10'h258};
    localparam logic [9:0]  FTC_VMIN_LUT   [8] = '{10'h000, 10'h03c, 10'h046, 10'h050,
                                                   10'h05a, 10'h064, 10'h078, 10'h096};
    localparam logic [4:0]  FTC_RETRY_LUT  [8] = '{5'h00, 5'h02, 5'h03, 5'h05,
                                                   5'h07, 5'h0a, 5'h0f, 5'h14};
    localparam logic [5:0]  FTC_MINSPD_LUT [8] = '{6'h01, 6'h02, 6'h04, 6'h06,
                                                   6'h0a, 6'h14, 6'h1e, 6'h32};
    localparam logic [3:0]  FTC_RATIO_LUT  [4] = '{4'h2, 4'h4, 4'h6, 4'h8};
    localparam logic [9:0]  FTC_DUTY_LUT   [4] = '{10'h00a, 10'h00f, 10'h014, 10'h019};

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        speed_valid;  // One-cycle pulse at the end of each electrical cycle.
        logic [15:0] speed;        // Electrical speed, 0.5 Hz units.
        logic        sync_lost;    // One-cycle pulse per loss of synchronisation.
        logic        motor_run;    // Level, motor is being driven.
        logic [9:0]  sense;        // Current sense amplifier output, 0.5 mV units.
        logic [9:0]  supply;       // Supply voltage, 0.1 V units.
        logic [9:0]  duty;         // Commanded duty, 0.1 percent units.
    } ftc_meas_t;

    typedef struct packed {
        logic        abn_en;
        logic        sync_en;
        logic        absent_en;
        logic [12:0] abn_limit;
        logic [3:0]  sync_count;
        logic [9:0]  absent_limit;
        logic        ov_auto;
        logic [9:0]  vmax;
        logic        uv_auto;
        logic [9:0]  vmin;
        logic [4:0]  retry_limit;
        logic [5:0]  min_speed;
        logic [3:0]  ratio;
        logic [9:0]  duty_floor;
    } ftc_thr_t;

endpackage : ftc_pkg

// [rtl/ftc_threshold_decode.sv]
// Turns the stored settings word into registered thresholds.
// Assumes the settings word is held stable by the register bank on the same clock.
module ftc_threshold_decode
    import ftc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [31:0] settings,
    output ftc_thr_t         thr
);

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    function automatic ftc_thr_t decode(input logic [31:0] s);
        ftc_thr_t t;
        t              = '0;
        t.abn_en       = s[FTC_ABN_EN_BIT];
        t.sync_en      = s[FTC_SYNC_EN_BIT];
        t.absent_en    = s[FTC_ABSENT_EN_BIT];
        t.abn_limit    = 13'(FTC_ABN_STEP * ({9'h0, s[FTC_ABN_LSB +: 4]} + 13'h1));
        t.sync_count   = {1'b0, s[FTC_SYNC_LSB +: 3]} + FTC_SYNC_BASE;
        t.absent_limit = FTC_ABSENT_LUT[s[FTC_ABSENT_LSB +: 3]];
        t.ov_auto      = s[FTC_OV_MODE_BIT];
        t.vmax         = FTC_VMAX_LUT[s[FTC_VMAX_LSB +: 3]];
        t.uv_auto      = s[FTC_UV_MODE_BIT];
        t.vmin         = FTC_VMIN_LUT[s[FTC_VMIN_LSB +: 3]];
        t.retry_limit  = FTC_RETRY_LUT[s[FTC_RETRY_LSB +: 3]];
        t.min_speed    = FTC_MINSPD_LUT[s[FTC_MINSPD_LSB +: 3]];
        t.ratio        = FTC_RATIO_LUT[s[FTC_RATIO_LSB +: 2]];
        t.duty_floor   = FTC_DUTY_LUT[s[FTC_DUTY_LSB +: 2]];
        return t;
    endfunction : decode

    // Thresholds of the reset word, so the checks run with code 0 limits
    // straight out of reset rather than with an all-zero table.
    localparam ftc_thr_t FTC_THR_RESET = decode(FTC_REG_RESET);

    // Registering the table output keeps the compare paths short; a new
    // setting therefore takes effect one cycle after it is stored.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            thr <= FTC_THR_RESET;
        end else begin
            thr <= decode(settings);
        end
    end

endmodule : ftc_threshold_decode

// [rtl/ftc_fault_threshold_config.sv]
// Fault threshold settings word and the lock and supply fault checks it steers.
// Assumes measurement strobes come from logic on clk_sys and need no synchroniser.
//
// Behaviour
// - Abnormal-speed limit is 250 Hz times code plus one.
// - Loss-of-sync fault after code plus two losses of synchronisation.
// - No-motor current threshold is selected sense voltage over amplifier gain.
// - Overvoltage mode 0 latches the fault; 1 clears it when supply recovers.
// - Upper supply limit: 0 no limit, else 20 to 60 volts.
// - Undervoltage mode 0 latches the fault; 1 clears it when supply recovers.
// - Lower supply limit: 0 no limit, else 6 to 15 volts.
// - Retry attempts: 0 unlimited, else 2 to 20 attempts.
// - Lock fault when speed drops below selected minimum, 0.5 to 25 Hz.
// - Abnormal-speed fault when speed ratio between cycles exceeds 2, 4, 6 or 8.
// - Target speed is zero when duty is below 1 to 2.5 percent.
// - Abnormal-speed detection runs only while its enable bit is set.
// - Loss-of-sync and no-motor detections run only while their enables are set.
module ftc_fault_threshold_config
    import ftc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        cfg_wr,
    input  wire logic [31:0] cfg_wdata,
    input  ftc_meas_t        meas,
    input  wire logic        fault_clear,
    input  wire logic        retry_attempt,
    output logic      [31:0] cfg_rdata,
    output logic             abn_speed_fault,
    output logic             sync_loss_fault,
    output logic             absent_motor_fault,
    output logic             low_speed_fault,
    output logic             ov_fault,
    output logic             uv_fault,
    output logic             retry_exhausted,
    output logic             target_zero
);

    // ------------------------------------------------------------------
    // Settings register and threshold decode
    // ------------------------------------------------------------------
    ftc_thr_t    thr;
    logic [15:0] prev_speed;
    logic        prev_valid;
    logic [3:0]  sync_cnt;
    logic [4:0]  retry_cnt;
    logic        speed_jump;
    logic        abn_hit;

    // The word is stored whole; the parity bit is kept but not checked here.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= FTC_REG_RESET;
        end else if (cfg_wr) begin
            cfg_rdata <= cfg_wdata;
        end
    end

    ftc_threshold_decode u_decode (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .settings (cfg_rdata),
        .thr      (thr)
    );

    // ------------------------------------------------------------------
    // Abnormal speed: absolute limit and cycle-to-cycle jump
    // ------------------------------------------------------------------
    // A jump is judged both ways, so a sudden drop counts as well as a surge.
    // Products are formed at 20 bits so a full-scale speed times 8 cannot wrap.
    assign speed_jump = prev_valid &&
                        ((20'(meas.speed) > 20'(prev_speed) * 20'(thr.ratio)) ||
                         (20'(prev_speed) > 20'(meas.speed) * 20'(thr.ratio)));
    assign abn_hit    = meas.speed_valid && thr.abn_en &&
                        (({3'h0, meas.speed[15:13]} != 6'h0) ||
                         (meas.speed[12:0] > thr.abn_limit) || speed_jump);

    // The first cycle after the motor starts running again has no reference speed to compare with.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_speed <= 16'h0;
            prev_valid <= 1'b0;
        end else if (!meas.motor_run) begin
            prev_valid <= 1'b0;
        end else if (meas.speed_valid) begin
            prev_speed <= meas.speed;
            prev_valid <= 1'b1;
        end
    end

    // A fresh hit wins over a clear in the same cycle.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            abn_speed_fault <= 1'b0;
        end else if (abn_hit) begin
            abn_speed_fault <= 1'b1;
        end else if (fault_clear) begin
            abn_speed_fault <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Loss of synchronisation
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_cnt        <= 4'h0;
            sync_loss_fault <= 1'b0;
        end else if (meas.sync_lost && thr.sync_en) begin
            if (sync_cnt + 4'h1 >= thr.sync_count) begin
                sync_loss_fault <= 1'b1;
                sync_cnt        <= 4'h0;
            end else begin
                sync_cnt <= sync_cnt + 4'h1;
            end
        end else if (fault_clear) begin
            sync_cnt        <= 4'h0;
            sync_loss_fault <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // No motor and minimum speed
    // ------------------------------------------------------------------
    // The amplifier output is compared with the selected voltage, which is
    // the same as comparing phase current with voltage over gain.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            absent_motor_fault <= 1'b0;
        end else if (thr.absent_en && meas.motor_run && meas.sense < thr.absent_limit) begin
            absent_motor_fault <= 1'b1;
        end else if (fault_clear) begin
            absent_motor_fault <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_speed_fault <= 1'b0;
        end else if (meas.motor_run && meas.speed_valid && meas.speed < {10'h0, thr.min_speed}) begin
            low_speed_fault <= 1'b1;
        end else if (fault_clear) begin
            low_speed_fault <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Supply window
    // ------------------------------------------------------------------
    // In latch mode a clear is refused while the supply is still out of bounds.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ov_fault <= 1'b0;
        end else if (thr.vmax != 10'h0 && meas.supply > thr.vmax) begin
            ov_fault <= 1'b1;
        end else if (thr.ov_auto || fault_clear) begin
            ov_fault <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            uv_fault <= 1'b0;
        end else if (thr.vmin != 10'h0 && meas.supply < thr.vmin) begin
            uv_fault <= 1'b1;
        end else if (thr.uv_auto || fault_clear) begin
            uv_fault <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Retry budget and zero command
    // ------------------------------------------------------------------
    // The counter saturates at 31, so a run of retries past the limit never wraps back out of the stop.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            retry_cnt <= 5'h0;
        end else if (retry_attempt && retry_cnt != 5'h1f) begin
            retry_cnt <= retry_cnt + 5'h1;
        end else if (fault_clear && !retry_attempt) begin
            retry_cnt <= 5'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            retry_exhausted <= 1'b0;
            target_zero     <= 1'b1;
        end else begin
            retry_exhausted <= (thr.retry_limit != 5'h0) && (retry_cnt >= thr.retry_limit);
            target_zero     <= meas.duty < thr.duty_floor;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_single_write;
        cfg_wr ##1 !cfg_wr;
    endsequence

    a_cfg_apply_lag: assert property (s_single_write |=> thr.abn_en == $past(cfg_wdata[30], 2))
        else $error("Enable did not apply two cycles after a write.");
    a_abn_decode: assert property (thr.abn_limit == 13'(FTC_ABN_STEP * ({9'h0, $past(cfg_rdata[27:24])} + 13'h1)))
        else $error("Abnormal speed limit does not match its code.");
    a_abn_gated: assert property ($rose(abn_speed_fault) |-> $past(thr.abn_en && meas.speed_valid))
        else $error("Abnormal speed fault rose while disabled.");
    a_jump_ratio: assert property (meas.speed_valid && thr.abn_en && speed_jump |=> abn_speed_fault)
        else $error("Speed jump did not raise the fault.");
    a_sync_count: assert property ($rose(sync_loss_fault) |-> $past(thr.sync_en && meas.sync_lost && sync_cnt + 4'h1 >= thr.sync_count))
        else $error("Sync loss fault rose before the count was reached.");
    a_absent_gate: assert property ($rose(absent_motor_fault) |-> $past(thr.absent_en && meas.sense < thr.absent_limit))
        else $error("No-motor fault rose without cause.");
    a_ov_latch_hold: assert property (ov_fault && !thr.ov_auto && !fault_clear |=> ov_fault)
        else $error("Latched overvoltage fault dropped by itself.");
    a_ov_auto_clear: assert property (ov_fault && thr.ov_auto && meas.supply <= thr.vmax |=> !ov_fault)
        else $error("Overvoltage fault did not clear automatically.");
    a_uv_auto_clear: assert property (uv_fault && thr.uv_auto && meas.supply >= thr.vmin |=> !uv_fault)
        else $error("Undervoltage fault did not clear automatically.");
    a_retry_unlimited: assert property (thr.retry_limit == 5'h0 |=> !retry_exhausted)
        else $error("Retry stop raised with unlimited retries.");
    a_low_speed_set: assert property (meas.motor_run && meas.speed_valid && meas.speed < {10'h0, thr.min_speed} |=> low_speed_fault)
        else $error("Low speed did not raise the lock fault.");
    a_zero_duty: assert property (meas.duty < thr.duty_floor |=> target_zero)
        else $error("Low duty did not force zero target.");

endmodule : ftc_fault_threshold_config

// [verif/tb_top.sv]
// Self-checking bench for the fault threshold settings word and the checks it steers.
// Assumes inc/ftc_pkg.sv and the rtl files are compiled first; one clock, async low reset.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end

module tb_top
    import ftc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals and expected thresholds
    // ------------------------------------------------------------------
    logic        clk_sys, rst_n, cfg_wr, fault_clear, retry_attempt;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic        abn_speed_fault, sync_loss_fault, absent_motor_fault, low_speed_fault;
    logic        ov_fault, uv_fault, retry_exhausted, target_zero;
    ftc_meas_t   meas, m;
    int          errors, n_checks;
    // Thresholds in the design's units: 0.1 V, 0.5 mV, 0.5 Hz and 0.1 percent.
    int vmax_t[8]  = '{0, 200, 250, 300, 350, 400, 500, 600};
    int vmin_t[8]  = '{0, 60, 70, 80, 90, 100, 120, 150};
    int sense_t[8] = '{10, 15, 20, 25, 40, 50, 60, 80};
    int retry_t[8] = '{0, 2, 3, 5, 7, 10, 15, 20};
    int minsp_t[8] = '{1, 2, 4, 6, 10, 20, 30, 50};
    int duty_t[4]  = '{10, 15, 20, 25};
    int ratio_t[4] = '{2, 4, 6, 8};

    // Half period of the 200 MHz clock.
    always #2.5 clk_sys = ~clk_sys;

    ftc_fault_threshold_config ftc_fault_threshold_config_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .meas(meas),
        .fault_clear(fault_clear), .retry_attempt(retry_attempt), .cfg_rdata(cfg_rdata),
        .abn_speed_fault(abn_speed_fault), .sync_loss_fault(sync_loss_fault),
        .absent_motor_fault(absent_motor_fault), .low_speed_fault(low_speed_fault),
        .ov_fault(ov_fault), .uv_fault(uv_fault), .retry_exhausted(retry_exhausted),
        .target_zero(target_zero)
    );

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    // Write waits two edges so that the new thresholds are in use on return.
    task automatic wr(input logic [31:0] w);
        @(posedge clk_sys);
        cfg_wr    <= 1'b1;
        cfg_wdata <= w;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask : wr

    // Applies the measurement image, with optional one-cycle strobes, and samples mid-cycle.
    task automatic apply(input logic v, input logic s);
        ftc_meas_t mm;
        mm = m;
        mm.speed_valid = v;
        mm.sync_lost = s;
        @(posedge clk_sys);
        meas <= mm;
        @(posedge clk_sys);
        meas <= m;
        @(negedge clk_sys);
    endtask : apply

    // Kind 0 pulses the fault clear, kind 1 reports one retry; the current image
    // is presented too, so a cause that was just removed is gone when the clear lands.
    task automatic pulse(input int k);
        @(posedge clk_sys);
        meas          <= m;
        fault_clear   <= (k == 0);
        retry_attempt <= (k == 1);
        @(posedge clk_sys);
        fault_clear   <= 1'b0;
        retry_attempt <= 1'b0;
        @(negedge clk_sys);
    endtask : pulse

    task automatic spd(input int v);
        m.speed = 16'(v);
        apply(1'b1, 1'b0);
    endtask : spd

    task automatic sup(input int v);
        m.supply = 10'(v);
        apply(1'b0, 1'b0);
    endtask : sup

    // Stopping the motor drops the previous-cycle speed, so ratios start afresh.
    task automatic rerun();
        m.motor_run = 1'b0;
        apply(1'b0, 1'b0);
        m.motor_run = 1'b1;
        apply(1'b0, 1'b0);
    endtask : rerun

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {clk_sys, rst_n, cfg_wr, fault_clear, retry_attempt} = '0;
        {cfg_wdata, meas, m, errors, n_checks} = '0;
        repeat (8) @(posedge clk_sys);
        `CHK(cfg_rdata, 32'h0000_0000)
        rst_n <= 1'b1;
        wr(32'hffff_ffff);
        @(negedge clk_sys);
        `CHK(cfg_rdata, 32'hffff_ffff)
        for (int c = 0; c < 4; c++) begin
            wr(32'(c));
            m.duty = 10'(duty_t[c] - 1);
            apply(1'b0, 1'b0);
            `CHK(target_zero, 1'b1)
            m.duty = 10'(duty_t[c]);
            apply(1'b0, 1'b0);
            `CHK(target_zero, 1'b0)
        end
        // Both supply limits in latch mode and then in automatic-clear mode.
        for (int c = 1; c < 8; c++) begin
            for (int md = 0; md < 2; md++) begin
                wr(32'((c << 14) | (c << 10) | (md << 17) | (md << 13)));
                sup(vmax_t[c] + 1);
                `CHK(ov_fault, 1'b1)
                sup(vmax_t[c]);
                `CHK(ov_fault, 1'(md == 0))
                pulse(0);
                `CHK(ov_fault, 1'b0)
                sup(vmin_t[c] - 1);
                `CHK(uv_fault, 1'b1)
                sup(vmax_t[c]);
                `CHK(uv_fault, 1'(md == 0))
                pulse(0);
                `CHK(uv_fault, 1'b0)
            end
        end
        wr(32'h0000_0000);
        sup(1023);
        `CHK(ov_fault, 1'b0)
        sup(0);
        `CHK(uv_fault, 1'b0)
        m.motor_run = 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(32'((1 << 28) | (c << 18)));
            m.sense = 10'(sense_t[c] - 1);
            apply(1'b0, 1'b0);
            `CHK(absent_motor_fault, 1'b1)
            m.sense = 10'(sense_t[c] + 1);
            pulse(0);
            `CHK(absent_motor_fault, 1'b0)
        end
        wr(32'(7 << 18));
        m.sense = 10'h000;
        apply(1'b0, 1'b0);
        `CHK(absent_motor_fault, 1'b0)
        m.sense = 10'h3ff;
        for (int c = 0; c < 8; c++) begin
            wr(32'(c << 4));
            spd(minsp_t[c] - 1);
            `CHK(low_speed_fault, 1'b1)
            spd(minsp_t[c]);
            pulse(0);
            `CHK(low_speed_fault, 1'b0)
        end
        rerun();
        for (int c = 0; c < 16; c++) begin
            wr(32'((1 << 30) | (c << 24) | (3 << 2)));
            spd((c + 1) * 500);
            `CHK(abn_speed_fault, 1'b0)
            spd((c + 1) * 500 + 1);
            `CHK(abn_speed_fault, 1'b1)
            pulse(0);
        end
        wr(32'(15 << 24));
        spd(65535);
        `CHK(abn_speed_fault, 1'b0)
        for (int r = 0; r < 4; r++) begin
            wr(32'((1 << 30) | (15 << 24) | (r << 2)));
            rerun();
            spd(100);
            spd(100 * ratio_t[r]);
            `CHK(abn_speed_fault, 1'b0)
            spd(100 * ratio_t[r] * ratio_t[r] + 1);
            `CHK(abn_speed_fault, 1'b1)
            pulse(0);
        end
        for (int c = 0; c < 8; c++) begin
            wr(32'((1 << 29) | (c << 21)));
            pulse(0);
            repeat (c + 1) apply(1'b0, 1'b1);
            `CHK(sync_loss_fault, 1'b0)
            apply(1'b0, 1'b1);
            `CHK(sync_loss_fault, 1'b1)
            pulse(0);
            `CHK(sync_loss_fault, 1'b0)
        end
        wr(32'(7 << 21));
        repeat (9) apply(1'b0, 1'b1);
        `CHK(sync_loss_fault, 1'b0)
        // The exhausted flag is registered behind the count, hence the extra cycle.
        for (int c = 0; c < 8; c++) begin
            wr(32'(c << 7));
            pulse(0);
            repeat ((c == 0) ? 24 : retry_t[c] - 1) pulse(1);
            @(negedge clk_sys);
            `CHK(retry_exhausted, 1'b0)
            pulse(1);
            @(negedge clk_sys);
            `CHK(retry_exhausted, 1'(c != 0))
        end
        summarize();
    end

    // A hang is cut short well beyond the 1100 or so cycles the sequence needs.
    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        summarize();
    end
endmodule : tb_top
